// ==== bench/etc_pin_source.sv ====
// External event source that drives the count input pin
`timescale 1ns/1ps
`default_nettype none
module etc_pin_source (
  // Clock reference
  input wire logic clk,
  // Event pin
  output logic pin
);
  initial pin = 1'b0;
  // Width in clocks: short widths test a prompt source, long ones a slow one
  task automatic pulses(input int n, input int w);
    repeat (n) begin
      repeat (w) @(negedge clk);
      pin = 1'b1;
      repeat (w) @(negedge clk);
      pin = 1'b0;
    end
  endtask : pulses
endmodule : etc_pin_source
`default_nettype wire

// ==== bench/tb_eight_bit_timer_counter_core.sv ====
// Self-checking bench for the eight bit timer counter core
`timescale 1ns/1ps
`default_nettype none
module tb_eight_bit_timer_counter_core;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] tickSourceSelect = 3'h0;
  logic [1:0] waveModeLow = 2'h0;
  logic waveModeBit2 = 1'b0;
  logic prescalerReset = 1'b0;
  logic countWrite = 1'b0;
  logic [7:0] countWriteData = 8'h00;
  logic compareWriteA = 1'b0;
  logic compareWriteB = 1'b0;
  logic [7:0] compareWriteData = 8'h00;
  logic [2:0] timerMaskRegister = 3'h7;
  logic [2:0] flagWriteOne = 3'h0;
  logic [2:0] irqServiced = 3'h0;
  wire logic externalCountInput;
  logic [7:0] countValue, compareValueA, compareValueB;
  logic [2:0] timerFlagRegister, irqRequest;
  logic timerTick, bottomHit, topHit, matchA, matchB;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;

  etc_timer_core uut (.clk, .rst_b, .tickSourceSelect, .waveModeLow,
    .waveModeBit2, .prescalerReset, .countWrite, .countWriteData,
    .countValue, .compareWriteA, .compareWriteB, .compareWriteData,
    .compareValueA, .compareValueB, .timerMaskRegister, .flagWriteOne,
    .irqServiced, .timerFlagRegister, .irqRequest, .externalCountInput,
    .timerTick, .bottomHit, .topHit, .matchA, .matchB);
  etc_pin_source src (.clk, .pin(externalCountInput));

  always #4 clk = ~clk;
  // Whole run needs about 2100 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Every helper starts and ends on a falling edge
  task automatic nc(int n);
    repeat (n) @(negedge clk);
  endtask : nc
  task automatic wc(logic [7:0] d);
    countWrite = 1'b1;
    countWriteData = d;
    nc(1);
    countWrite = 1'b0;
  endtask : wc
  task automatic wcmp(logic [1:0] ab, logic [7:0] d);
    {compareWriteB, compareWriteA} = ab;
    compareWriteData = d;
    nc(1);
    {compareWriteB, compareWriteA} = 2'b00;
  endtask : wcmp
  task automatic run(int n);
    tickSourceSelect = 3'h1;
    nc(n);
    tickSourceSelect = 3'h0;
  endtask : run

  task automatic t_reset;
    chk("count", 8'h00, countValue);
    chk("compare a", 8'h00, compareValueA);
    chk("compare b", 8'h00, compareValueB);
    chk("flags", 3'h0, timerFlagRegister);
    chk("bottom", 1'b1, bottomHit);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_stop;
    wc(8'h05);
    nc(20);
    chk("held count", 8'h05, countValue);
    chk("bottom", 1'b0, bottomHit);
    $display("t_stop done");
  endtask : t_stop

  task automatic t_wrap;
    wc(8'hff);
    chk("top", 1'b1, topHit);
    run(1);
    chk("wrapped", 8'h00, countValue);
    nc(1);
    chk("overflow", 3'h1, timerFlagRegister);
    chk("request", 3'h1, irqRequest);
    timerMaskRegister = 3'h6;
    nc(1);
    chk("masked", 3'h0, irqRequest);
    timerMaskRegister = 3'h7;
    flagWriteOne = 3'h1;
    nc(1);
    flagWriteOne = 3'h0;
    chk("ovf cleared", 3'h0, timerFlagRegister);
    $display("t_wrap done");
  endtask : t_wrap

  task automatic t_block;
    wcmp(2'b10, 8'h05);
    chk("compare b", 8'h05, compareValueB);
    wc(8'h05);
    tickSourceSelect = 3'h1;
    #1;
    chk("blocked pulse", 1'b0, matchB);
    nc(2);
    tickSourceSelect = 3'h0;
    nc(2);
    chk("blocked", 3'h0, timerFlagRegister);
    wc(8'h03);
    tickSourceSelect = 3'h1;
    nc(2);
    chk("match b pulse", 1'b1, matchB);
    nc(1);
    tickSourceSelect = 3'h0;
    nc(2);
    chk("match b", 3'h4, timerFlagRegister);
    chk("request b", 3'h4, irqRequest);
    irqServiced = 3'h4;
    nc(1);
    irqServiced = 3'h0;
    chk("serviced", 3'h0, timerFlagRegister);
    $display("t_block done");
  endtask : t_block

  task automatic t_ctc;
    waveModeLow = 2'h2;
    wcmp(2'b01, 8'h03);
    chk("compare a", 8'h03, compareValueA);
    wc(8'h00);
    tickSourceSelect = 3'h1;
    for (int i = 1; i < 9; i++) begin
      nc(1);
      chk("ctc count", 16'(i % 4), countValue);
      chk("match a pulse", {15'h0, i % 4 == 3}, matchA);
    end
    tickSourceSelect = 3'h0;
    nc(2);
    chk("match a", 3'h2, timerFlagRegister);
    $display("t_ctc done");
  endtask : t_ctc

  task automatic t_prio;
    waveModeLow = 2'h0;
    tickSourceSelect = 3'h1;
    nc(3);
    wc(8'h40);
    chk("write wins", 8'h40, countValue);
    tickSourceSelect = 3'h0;
    $display("t_prio done");
  endtask : t_prio

  task automatic t_buf;
    waveModeLow = 2'h3;
    wcmp(2'b01, 8'h20);
    chk("buffered a", 8'h03, compareValueA);
    wc(8'hfe);
    run(3);
    chk("loaded a", 8'h20, compareValueA);
    chk("top ovf", 1'b1, timerFlagRegister[0]);
    $display("t_buf done");
  endtask : t_buf

  task automatic t_pre;
    int n;
    int dv[4] = '{8, 64, 256, 1024};
    waveModeLow = 2'h0;
    for (int i = 0; i < 4; i++) begin
      tickSourceSelect = 3'(i + 2);
      nc(1);
      n = 0;
      while (timerTick !== 1'b1 && n < 2100) begin
        nc(1);
        n++;
      end
      n = 0;
      do begin
        nc(1);
        n++;
      end while (timerTick !== 1'b1 && n < 2100);
      chk("tick period", 16'(dv[i]), 16'(n));
    end
    nc(3);
    prescalerReset = 1'b1;
    nc(1);
    prescalerReset = 1'b0;
    tickSourceSelect = 3'h2;
    nc(6);
    chk("prescaler held", 1'b0, timerTick);
    nc(1);
    chk("prescaler restart", 1'b1, timerTick);
    tickSourceSelect = 3'h0;
    $display("t_pre done");
  endtask : t_pre

  // Compare A sets the top; a service at the top tick must lose
  task automatic t_topa;
    waveModeBit2 = 1'b1;
    waveModeLow = 2'h3;
    flagWriteOne = 3'h7;
    wc(8'h1f);
    flagWriteOne = 3'h0;
    tickSourceSelect = 3'h1;
    nc(1);
    chk("top a", 1'b1, topHit);
    irqServiced = 3'h1;
    nc(1);
    irqServiced = 3'h0;
    tickSourceSelect = 3'h0;
    chk("top a clear", 8'h00, countValue);
    chk("top a flags", 3'h3, timerFlagRegister);
    waveModeBit2 = 1'b0;
    $display("t_topa done");
  endtask : t_topa

  task automatic t_pin;
    tickSourceSelect = 3'h7;
    wc(8'h00);
    src.pulses(3, 4);
    nc(8);
    chk("rise count", 8'h03, countValue);
    tickSourceSelect = 3'h6;
    wc(8'h00);
    src.pulses(2, 4);
    nc(8);
    chk("fall count", 8'h02, countValue);
    tickSourceSelect = 3'h0;
    $display("t_pin done");
  endtask : t_pin

  // Just before t_rerun, since phase correct mode leaves the direction down
  task automatic t_down;
    waveModeLow = 2'h1;
    wc(8'hfe);
    tickSourceSelect = 3'h1;
    nc(1);
    chk("up", 8'hff, countValue);
    nc(1);
    chk("down", 8'hfe, countValue);
    tickSourceSelect = 3'h0;
    $display("t_down done");
  endtask : t_down

  task automatic t_rerun;
    rst_b = 1'b0;
    nc(2);
    rst_b = 1'b1;
    chk("reset count", 8'h00, countValue);
    chk("reset flags", 3'h0, timerFlagRegister);
    chk("reset compare a", 8'h00, compareValueA);
    tickSourceSelect = 3'h1;
    nc(1);
    tickSourceSelect = 3'h0;
    chk("up after reset", 8'h01, countValue);
    $display("t_rerun done");
  endtask : t_rerun

  initial begin
    nc(8);
    rst_b = 1'b1;
    t_reset();
    t_stop();
    t_wrap();
    t_block();
    t_ctc();
    t_prio();
    t_buf();
    t_pre();
    t_pin();
    t_topa();
    t_down();
    t_rerun();
    finish_test();
  end
endmodule : tb_eight_bit_timer_counter_core
`default_nettype wire

// ==== src/etc_consts.svh ====
// Constants of the eight bit timer counter core
`ifndef ETC_CONSTS_SVH
`define ETC_CONSTS_SVH
`define ETC_BOTTOM 8'h00
`define ETC_MAX 8'hff
`define ETC_CS_STOP 3'h0
`define ETC_CS_DIV1 3'h1
`define ETC_CS_DIV8 3'h2
`define ETC_CS_DIV64 3'h3
`define ETC_CS_DIV256 3'h4
`define ETC_CS_DIV1024 3'h5
`define ETC_CS_EXT_FALL 3'h6
`define ETC_CS_EXT_RISE 3'h7
`define ETC_WM_NORMAL 3'h0
`define ETC_WM_PCPWM 3'h1
`define ETC_WM_CTC 3'h2
`define ETC_WM_FAST 3'h3
`define ETC_WM_PCPWM_A 3'h5
`define ETC_WM_FAST_A 3'h7
`define ETC_DIV8_LAST 3'h7
`define ETC_DIV64_LAST 6'h3f
`define ETC_DIV256_LAST 8'hff
`define ETC_DIV1024_LAST 10'h3ff
`define ETC_FLAG_OVF 0
`define ETC_FLAG_MA 1
`define ETC_FLAG_MB 2
`endif

// ==== src/etc_pkg.sv ====
// Types of the eight bit timer counter core
package etc_pkg;
  typedef logic [7:0] etc_count_t;
  typedef enum logic [1:0] {
    ETC_OP_HOLD = 2'b00,
    ETC_OP_INC = 2'b01,
    ETC_OP_DEC = 2'b10,
    ETC_OP_CLR = 2'b11
  } etc_op_e;
endpackage : etc_pkg

// ==== src/etc_timer_core.sv ====
// Eight bit timer counter core with prescaler, compare units and flags
//
// Overview of operation
// - Count value and compare values A and B are eight bit registers.
// - Each request shows as a flag and is gated by its own mask bit.
// - Tick comes from prescaled clock or external pin edge, chosen by select.
// - Select value zero stops the counter, which holds its value.
// - The select field alone decides the tick source.
// - Both compare values are compared with the count continuously.
// - Match sets its flag; unmasked flag raises a compare request.
// - Bottom indication is high whenever the count is zero.
// - Count value 255 is the counter maximum.
// - Top is maximum or compare A per wave mode; top flagged there.
// - On each tick the counter clears, increments or decrements.
// - Software may read and write the count at any time.
// - A count write beats a coincident count or clear.
// - Wave mode is three bits: two in control A, one in control B.
// - Overflow flag set where the mode defines; unmasked it requests.
// - Compare values are double buffered in PWM modes only, loaded at the top tick.
// - Mode 0 counts up, wraps 255 to 0 and sets overflow then.
// - Mode 2 clears the count when it matches compare A.
// - Match flag sets on the next tick; clears on service or write one.
// - A count write blocks all matches on the next tick, even stopped.
`timescale 1ns/1ps
`default_nettype none
`include "etc_consts.svh"

module etc_timer_core (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control fields
  input wire logic [2:0] tickSourceSelect,
  input wire logic [1:0] waveModeLow,
  input wire logic waveModeBit2,
  input wire logic prescalerReset,
  // Count value access
  input wire logic countWrite,
  input wire logic [7:0] countWriteData,
  output logic [7:0] countValue,
  // Compare value access
  input wire logic compareWriteA,
  input wire logic compareWriteB,
  input wire logic [7:0] compareWriteData,
  output logic [7:0] compareValueA,
  output logic [7:0] compareValueB,
  // Flags, masks and service
  input wire logic [2:0] timerMaskRegister,
  input wire logic [2:0] flagWriteOne,
  input wire logic [2:0] irqServiced,
  output logic [2:0] timerFlagRegister,
  output logic [2:0] irqRequest,
  // External event pin
  input wire logic externalCountInput,
  // Status
  output logic timerTick,
  output logic bottomHit,
  output logic topHit,
  output logic matchA,
  output logic matchB
);

  // Wave mode assembled from both control registers
  logic [2:0] waveMode;
  assign waveMode = {waveModeBit2, waveModeLow};

  logic pwmMode;
  logic phaseMode;
  logic topIsA;
  assign pwmMode = (waveMode == `ETC_WM_PCPWM) ||
    (waveMode == `ETC_WM_FAST) || (waveMode == `ETC_WM_PCPWM_A) ||
    (waveMode == `ETC_WM_FAST_A);
  assign phaseMode = (waveMode == `ETC_WM_PCPWM) ||
    (waveMode == `ETC_WM_PCPWM_A);
  assign topIsA = (waveMode == `ETC_WM_CTC) ||
    (waveMode == `ETC_WM_PCPWM_A) || (waveMode == `ETC_WM_FAST_A);

  // Prescaler
  logic [9:0] preCnt_q;
  always_ff @(posedge clk) begin
    if (!rst_b || prescalerReset) begin
      preCnt_q <= 10'h000;
    end else begin
      preCnt_q <= preCnt_q + 10'h001;
    end
  end

  // Three stage sampler on the pin; stage one feeds stage two only
  logic ext1_q;
  logic ext2_q;
  logic ext3_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ext1_q <= 1'b0;
      ext2_q <= 1'b0;
      ext3_q <= 1'b0;
    end else begin
      ext1_q <= externalCountInput;
      ext2_q <= ext1_q;
      ext3_q <= ext2_q;
    end
  end

  // Agreement of the later stages gives a filtered level
  logic extLevel_q;
  logic extNext;
  assign extNext = (ext2_q == ext3_q) ? ext3_q : extLevel_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      extLevel_q <= 1'b0;
    end else begin
      extLevel_q <= extNext;
    end
  end
  logic extRise;
  logic extFall;
  assign extRise = extNext && !extLevel_q;
  assign extFall = !extNext && extLevel_q;

  // Tick source selection
  logic tick;
  assign tick =
    (tickSourceSelect == `ETC_CS_DIV1) ? 1'b1 :
    (tickSourceSelect == `ETC_CS_DIV8) ?
      (preCnt_q[2:0] == `ETC_DIV8_LAST) :
    (tickSourceSelect == `ETC_CS_DIV64) ?
      (preCnt_q[5:0] == `ETC_DIV64_LAST) :
    (tickSourceSelect == `ETC_CS_DIV256) ?
      (preCnt_q[7:0] == `ETC_DIV256_LAST) :
    (tickSourceSelect == `ETC_CS_DIV1024) ?
      (preCnt_q == `ETC_DIV1024_LAST) :
    (tickSourceSelect == `ETC_CS_EXT_FALL) ? extFall :
    (tickSourceSelect == `ETC_CS_EXT_RISE) ? extRise :
    1'b0;
  assign timerTick = tick;

  // Counter, direction, compare buffers
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic down_q;
  logic down_d;
  logic [7:0] ocrA_q;
  logic [7:0] ocrB_q;
  logic [7:0] bufA_q;
  logic [7:0] bufB_q;
  logic [7:0] topValue;
  assign topValue = topIsA ? ocrA_q : `ETC_MAX;

  logic atTop;
  logic atBottom;
  logic atMax;
  assign atTop = (count_q == topValue);
  assign atBottom = (count_q == `ETC_BOTTOM);
  assign atMax = (count_q == `ETC_MAX);
  assign bottomHit = atBottom;
  assign topHit = atTop;

  // Comparators run in every mode
  logic eqA;
  logic eqB;
  assign eqA = (count_q == ocrA_q);
  assign eqB = (count_q == ocrB_q);

  // Operation chosen by mode
  etc_pkg::etc_op_e op;
  assign op =
    !tick ? etc_pkg::ETC_OP_HOLD :
    (phaseMode && (down_q ? atBottom : !atTop)) ?
      (down_q ? etc_pkg::ETC_OP_INC : etc_pkg::ETC_OP_INC) :
    (phaseMode && atTop) ? etc_pkg::ETC_OP_DEC :
    (phaseMode && down_q) ? etc_pkg::ETC_OP_DEC :
    (topIsA && atTop) ? etc_pkg::ETC_OP_CLR :
    (pwmMode && atTop) ? etc_pkg::ETC_OP_CLR :
    etc_pkg::ETC_OP_INC;

  // Phase correct turns at top and bottom
  assign down_d = !phaseMode ? 1'b0 :
    (tick && atTop) ? 1'b1 :
    (tick && atBottom) ? 1'b0 : down_q;

  always_comb begin
    case (op)
      etc_pkg::ETC_OP_HOLD: count_d = count_q;
      etc_pkg::ETC_OP_INC: count_d = count_q + 8'h01;
      etc_pkg::ETC_OP_DEC: count_d = count_q - 8'h01;
      etc_pkg::ETC_OP_CLR: count_d = `ETC_BOTTOM;
      default: count_d = count_q;
    endcase
  end

  // Software write wins over tick
  logic [7:0] countNext;
  assign countNext = countWrite ? countWriteData : count_d;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_q <= `ETC_BOTTOM;
      down_q <= 1'b0;
    end else begin
      count_q <= countNext;
      down_q <= down_d;
    end
  end
  assign countValue = count_q;

  // Buffer load point: the top tick in every PWM mode
  logic loadPoint;
  assign loadPoint = tick && (phaseMode ? atTop : (pwmMode && atTop));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bufA_q <= `ETC_BOTTOM;
      bufB_q <= `ETC_BOTTOM;
    end else begin
      if (compareWriteA) begin
        bufA_q <= compareWriteData;
      end
      if (compareWriteB) begin
        bufB_q <= compareWriteData;
      end
    end
  end

  // Non PWM modes write straight through; PWM modes wait for the point
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ocrA_q <= `ETC_BOTTOM;
      ocrB_q <= `ETC_BOTTOM;
    end else begin
      if (!pwmMode && compareWriteA) begin
        ocrA_q <= compareWriteData;
      end else if (pwmMode && loadPoint) begin
        ocrA_q <= bufA_q;
      end
      if (!pwmMode && compareWriteB) begin
        ocrB_q <= compareWriteData;
      end else if (pwmMode && loadPoint) begin
        ocrB_q <= bufB_q;
      end
    end
  end
  assign compareValueA = ocrA_q;
  assign compareValueB = ocrB_q;

  // Write block lasts until the next tick, so a stopped timer keeps it
  logic block_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      block_q <= 1'b0;
    end else if (countWrite) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  // Match is taken on the tick that follows the equal count
  assign matchA = tick && eqA && !block_q;
  assign matchB = tick && eqB && !block_q;

  // Overflow point per mode
  logic ovfEvent;
  assign ovfEvent = tick && (phaseMode ? atBottom :
    (pwmMode ? atTop : atMax));

  // Flags: a set in the same cycle as a clear wins
  logic [2:0] setVec;
  logic [2:0] clrVec;
  logic [2:0] flag_q;
  assign setVec = {matchB, matchA, ovfEvent};
  assign clrVec = flagWriteOne | irqServiced;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flag_q <= 3'h0;
    end else begin
      flag_q <= setVec | (flag_q & ~clrVec);
    end
  end
  assign timerFlagRegister = flag_q;
  assign irqRequest = flag_q & timerMaskRegister;

  // Checks
  ovf_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
    (waveMode == `ETC_WM_NORMAL && tick && atMax && !countWrite) |=>
      (count_q == `ETC_BOTTOM) && flag_q[`ETC_FLAG_OVF])
    else $error("normal mode wrap missed");
  stop_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (tickSourceSelect == `ETC_CS_STOP && !countWrite) |=>
      $stable(count_q))
    else $error("stopped counter moved");
  write_wins_a: assert property (@(posedge clk) disable iff (!rst_b)
    countWrite |=> count_q == $past(countWriteData))
    else $error("count write lost");
  ctc_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    (waveMode == `ETC_WM_CTC && tick && eqA && !countWrite) |=>
      count_q == `ETC_BOTTOM)
    else $error("ctc clear missed");
  match_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    (tick && eqA && !block_q) |=> flag_q[`ETC_FLAG_MA])
    else $error("match flag a not set");
  block_match_a: assert property (@(posedge clk) disable iff (!rst_b)
    countWrite ##1 (!countWrite && tick) |-> !matchA && !matchB)
    else $error("match not blocked");
  bottom_ind_a: assert property (@(posedge clk) disable iff (!rst_b)
    bottomHit == (countValue == `ETC_BOTTOM))
    else $error("bottom indication wrong");
  irq_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    (irqServiced == 3'h0 && flagWriteOne == 3'h0 && ovfEvent) |=>
      irqRequest[`ETC_FLAG_OVF] == timerMaskRegister[`ETC_FLAG_OVF])
    else $error("overflow request gating wrong");
  clr_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    (flagWriteOne[`ETC_FLAG_MB] && !matchB) |=> !flag_q[`ETC_FLAG_MB])
    else $error("match b flag not cleared");
  step_up_a: assert property (@(posedge clk) disable iff (!rst_b)
    (waveMode == `ETC_WM_NORMAL && tick && !countWrite) |=>
      count_q == $past(count_q) + 8'h01)
    else $error("normal mode step wrong");
  turn_down_a: assert property (@(posedge clk) disable iff (!rst_b)
    (phaseMode && tick && atTop && !countWrite) |=> down_q)
    else $error("phase mode did not turn at top");
  pwm_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (pwmMode && !loadPoint) |=> $stable(ocrA_q) && $stable(ocrB_q))
    else $error("compare value moved between load points");
  set_wins_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ovfEvent && clrVec[`ETC_FLAG_OVF]) |=> flag_q[`ETC_FLAG_OVF])
    else $error("overflow clear beat its set");
  // Pin ticks only once both late sampler stages agree
  ext_tick_a: assert property (@(posedge clk) disable iff (!rst_b)
    (tickSourceSelect == `ETC_CS_EXT_RISE && tick) |->
      ext2_q && ext3_q && !extLevel_q)
    else $error("external tick without edge");
  fall_tick_a: assert property (@(posedge clk) disable iff (!rst_b)
    (tickSourceSelect == `ETC_CS_EXT_FALL && tick) |->
      !ext2_q && !ext3_q && extLevel_q)
    else $error("external fall tick without edge");

  cov_wrap_c: cover property (@(posedge clk) ovfEvent);
  cov_ctc_c: cover property (@(posedge clk)
    waveMode == `ETC_WM_CTC && matchA);
  cov_block_c: cover property (@(posedge clk) countWrite ##1 tick);
  cov_ext_c: cover property (@(posedge clk)
    tickSourceSelect == `ETC_CS_EXT_FALL && tick);

endmodule : etc_timer_core
`default_nettype wire
